/* test/ptb_time_base_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ptb_regs.svh"

// ***************************************************************
// bench signals and design instance
// ***************************************************************
module ptb_time_base_tb_top
  import ptb_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic irq_o;
  logic tb_event_o;
  logic special_event_o;
  int err_total = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  int ev_n = 0;
  int sp_n = 0;
  logic [31:0] rd;
  logic [31:0] a;
  logic [31:0] g;
  logic [31:0] cfgs [5] = '{32'h8000, 32'h8020, 32'h8004, 32'h8002, 32'h8003};
  logic [31:0] gaps [5] = '{32'h4, 32'hc, 32'h10, 32'h6, 32'h3};
  int s;
  int s2;

  ptb_time_base i_ptb_time_base (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .tb_event_o(tb_event_o), .special_event_o(special_event_o)
  );

  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    ev_n <= ev_n + int'(tb_event_o === 1'b1);
    sp_n <= sp_n + int'(special_event_o === 1'b1);
    if (cyc_cnt == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ***************************************************************
  // bus and checking tasks
  // ***************************************************************
  task automatic wb_acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    sel_i <= 4'hf;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wb_wr(input logic [7:0] ad, input logic [31:0] d);
    wb_acc(1'b1, ad, d);
  endtask

  task automatic wb_rd(input logic [7:0] ad);
    wb_acc(1'b0, ad, 32'h0000_0000);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // cycles between two event pulses
  task automatic gap(output logic [31:0] n);
    int i;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (tb_event_o !== 1'b1 && i < 500);
    n = 32'h0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tb_event_o !== 1'b1 && n < 500);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (cfgs[i]) begin
      wb_rd(8'h00 + 8'(i * 4));
      chk(rd, 32'h0);
    end
    wb_rd(8'h1c);
    chk(rd, 32'h0);
    // direction is known to be up here, straight after reset
    wb_wr(`PTB_ADDR_COUNT, 32'hffff);
    wb_rd(`PTB_ADDR_COUNT);
    chk(rd, 32'h7fff);
    wb_wr(`PTB_ADDR_COUNT, 32'h0);
    wb_wr(`PTB_ADDR_PERIOD, 32'h3);
    foreach (cfgs[i]) begin
      wb_wr(`PTB_ADDR_CTRL, 32'h0);
      wb_wr(`PTB_ADDR_CTRL, cfgs[i]);
      gap(g);
      gap(g);
      chk(g, gaps[i]);
    end
    wb_rd(`PTB_ADDR_STATUS);
    chk(rd & 32'h1, 32'h1);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb_wr(`PTB_ADDR_ENABLE, 32'h3);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wb_wr(`PTB_ADDR_CTRL, 32'h0);
    wb_wr(`PTB_ADDR_CLEAR, 32'h3);
    wb_rd(`PTB_ADDR_STATUS);
    chk(rd, 32'h0);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb_wr(`PTB_ADDR_COUNT, 32'h0);
    wb_wr(`PTB_ADDR_SEVCMP, 32'h2);
    s = sp_n;
    wb_wr(`PTB_ADDR_CTRL, 32'h8000);
    repeat (30) @(posedge clk_i);
    chk({31'h0, sp_n != s}, 32'h1);
    wb_rd(`PTB_ADDR_STATUS);
    chk(rd & 32'h2, 32'h2);
    wb_wr(`PTB_ADDR_CTRL, 32'h0);
    wb_wr(`PTB_ADDR_PERIOD, 32'h64);
    wb_wr(`PTB_ADDR_CTRL, 32'h8002);
    s = 0;
    do begin
      wb_rd(`PTB_ADDR_COUNT);
      s++;
    end while (rd[15] !== 1'b1 && s < 300);
    chk(rd & 32'h8000, 32'h8000);
    wb_wr(`PTB_ADDR_CTRL, 32'h0);
    wb_rd(`PTB_ADDR_COUNT);
    a = rd;
    repeat (10) @(posedge clk_i);
    wb_rd(`PTB_ADDR_COUNT);
    chk(rd, a);
    wb_wr(`PTB_ADDR_PERIOD, 32'h3);
    wb_wr(`PTB_ADDR_COUNT, 32'h0);
    s = ev_n;
    wb_wr(`PTB_ADDR_CTRL, 32'h8021);
    repeat (40) @(posedge clk_i);
    chk(32'(ev_n - s), 32'h1);
    wb_rd(`PTB_ADDR_CTRL);
    chk(rd, 32'h0021);
    wb_rd(`PTB_ADDR_COUNT);
    chk(rd, 32'h0);
    wb_wr(`PTB_ADDR_PERIOD, 32'h0);
    wb_wr(`PTB_ADDR_SEVCMP, 32'h0);
    s = ev_n;
    s2 = sp_n;
    wb_wr(`PTB_ADDR_CTRL, 32'h8000);
    wb_wr(`PTB_ADDR_PERIOD, 32'h5);
    wb_rd(`PTB_ADDR_PERIOD);
    chk(rd, 32'h0);
    repeat (40) @(posedge clk_i);
    chk(32'(ev_n - s + sp_n - s2), 32'h0);
    wb_wr(`PTB_ADDR_CTRL, 32'h0);
    wb_wr(`PTB_ADDR_PERIOD, 32'h5);
    wb_rd(`PTB_ADDR_PERIOD);
    chk(rd, 32'h5);
    wrap_up();
  end
endmodule
`default_nettype wire

/* verilog/ptb_pkg.sv */
`include "ptb_regs.svh"

package ptb_pkg;

  typedef enum logic [1:0] {
    ptb_free = `PTB_MODE_FREE,
    ptb_shot = `PTB_MODE_SHOT,
    ptb_updn = `PTB_MODE_UPDN,
    ptb_updn_dbl = `PTB_MODE_UPDN_DBL
  } ptb_mode_t;

  typedef struct packed {
    logic run;
    logic [6:0] spare;
    logic [3:0] ops;
    logic [1:0] pre;
    ptb_mode_t mode;
  } ptb_ctrl_t;

  typedef struct packed {
    logic special;
    logic period;
  } ptb_evt_t;

endpackage

/* verilog/ptb_regs.svh */
`ifndef PTB_REGS_SVH
`define PTB_REGS_SVH

// ***************************************************************
// register byte offsets on the wishbone bus
// ***************************************************************
`define PTB_ADDR_CTRL 8'h00
`define PTB_ADDR_COUNT 8'h04
`define PTB_ADDR_PERIOD 8'h08
`define PTB_ADDR_SEVCMP 8'h0c
`define PTB_ADDR_STATUS 8'h10
`define PTB_ADDR_CLEAR 8'h14
`define PTB_ADDR_ENABLE 8'h18

// ***************************************************************
// field positions
// ***************************************************************
`define PTB_RUN_BIT 15
`define PTB_DIR_BIT 15
`define PTB_OPS_LSB 4
`define PTB_PRE_LSB 2
`define PTB_MODE_LSB 0
`define PTB_EVT_PERIOD_BIT 0
`define PTB_EVT_SPECIAL_BIT 1

// ***************************************************************
// widths, codes and reset values
// ***************************************************************
`define PTB_CNT_W 15
`define PTB_MODE_FREE 2'h0
`define PTB_MODE_SHOT 2'h1
`define PTB_MODE_UPDN 2'h2
`define PTB_MODE_UPDN_DBL 2'h3
`define PTB_PRE_LIM_1 6'h00
`define PTB_PRE_LIM_4 6'h03
`define PTB_PRE_LIM_16 6'h0f
`define PTB_PRE_LIM_64 6'h3f
`define PTB_CTRL_RST 16'h0000
`define PTB_COUNT_RST 15'h0000
`define PTB_PERIOD_RST 15'h0000
`define PTB_SEVCMP_RST 15'h0000
`define PTB_EVT_RST 2'h0

`endif

/* verilog/ptb_time_base.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ptb_regs.svh"

module ptb_time_base
  import ptb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  output logic tb_event_o,
  output logic special_event_o
);

  // ***************************************************************
  // functions
  // ***************************************************************
  function automatic logic [15:0] ptb_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0] sel);
    ptb_merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                 sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic [5:0] ptb_pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0: ptb_pre_limit = `PTB_PRE_LIM_1;
      2'h1: ptb_pre_limit = `PTB_PRE_LIM_4;
      2'h2: ptb_pre_limit = `PTB_PRE_LIM_16;
      default: ptb_pre_limit = `PTB_PRE_LIM_64;
    endcase
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  ptb_ctrl_t ctrl_reg, ctrl_next;
  logic [`PTB_CNT_W-1:0] count_reg, count_next;
  logic dir_reg, dir_next;
  logic [`PTB_CNT_W-1:0] period_reg, period_next;
  logic [`PTB_CNT_W-1:0] sevcmp_reg, sevcmp_next;
  logic [5:0] pre_cnt_reg, pre_cnt_next;
  logic [3:0] post_cnt_reg, post_cnt_next;
  ptb_evt_t status_reg, status_next;
  ptb_evt_t enable_reg, enable_next;
  logic ack_reg;
  logic [31:0] dat_reg, dat_next;
  logic evt_reg;
  logic sev_reg;

  // ***************************************************************
  // wishbone decode
  // ***************************************************************
  wire req = cyc_i & stb_i;
  wire wr_stb = req & we_i & ack_reg;
  wire rd_take = req & ~ack_reg;
  wire hit_ctrl = adr_i == `PTB_ADDR_CTRL;
  wire hit_count = adr_i == `PTB_ADDR_COUNT;
  wire hit_period = adr_i == `PTB_ADDR_PERIOD;
  wire hit_sevcmp = adr_i == `PTB_ADDR_SEVCMP;
  wire hit_status = adr_i == `PTB_ADDR_STATUS;
  wire hit_clear = adr_i == `PTB_ADDR_CLEAR;
  wire hit_enable = adr_i == `PTB_ADDR_ENABLE;
  wire wr_ctrl = wr_stb & hit_ctrl;
  wire wr_count = wr_stb & hit_count & (|sel_i[1:0]);
  wire wr_period = wr_stb & hit_period & (|sel_i[1:0]);
  wire wr_sevcmp = wr_stb & hit_sevcmp & (|sel_i[1:0]);
  wire wr_clear = wr_stb & hit_clear & sel_i[0];
  wire wr_enable = wr_stb & hit_enable & sel_i[0];
  wire [15:0] wdat = dat_i[15:0];
  wire [15:0] ctrl_wr_val = ptb_merge(ctrl_reg, wdat, sel_i[1:0]);
  wire [15:0] count_wr_val = ptb_merge({dir_reg, count_reg}, wdat, sel_i[1:0]);
  wire [15:0] period_wr_val = ptb_merge({1'b0, period_reg}, wdat, sel_i[1:0]);
  wire [15:0] sevcmp_wr_val = ptb_merge({1'b0, sevcmp_reg}, wdat, sel_i[1:0]);

  // ***************************************************************
  // read data
  // ***************************************************************
  wire [15:0] rd_count = {dir_reg, count_reg};
  wire [15:0] rd_mux =
    hit_ctrl ? ctrl_reg :
    hit_count ? rd_count :
    hit_period ? {1'b0, period_reg} :
    hit_sevcmp ? {1'b0, sevcmp_reg} :
    hit_status ? {14'h0000, status_reg} :
    hit_enable ? {14'h0000, enable_reg} : 16'h0000;

  // ***************************************************************
  // time base core
  // ***************************************************************
  wire zero_period = period_reg == `PTB_PERIOD_RST;
  wire active = ctrl_reg.run & ~zero_period;
  wire tick = active & (pre_cnt_reg == ptb_pre_limit(ctrl_reg.pre));
  wire at_period = count_reg == period_reg;
  wire at_zero = count_reg == `PTB_COUNT_RST;
  wire updown = ctrl_reg.mode[1];
  wire is_free = ctrl_reg.mode == ptb_free;
  wire is_shot = ctrl_reg.mode == ptb_shot;
  wire is_dbl = ctrl_reg.mode == ptb_updn_dbl;
  wire up_match = tick & ~dir_reg & at_period;
  wire down_turn = tick & updown & dir_reg & at_zero;
  wire shot_end = is_shot & up_match;
  // events that qualify for the postscaler
  wire ev_raw = (~updown & up_match) | down_turn | (is_dbl & up_match);
  wire post_hit = post_cnt_reg == ctrl_reg.ops;
  wire tb_event = is_shot ? up_match : (ev_raw & post_hit);
  wire sev_hit = tick & ~dir_reg & (count_reg == sevcmp_reg);
  wire period_locked = zero_period & ctrl_reg.run;

  always_comb begin
    count_next = count_reg;
    dir_next = dir_reg;
    if (wr_count) begin
      count_next = count_wr_val[`PTB_CNT_W-1:0];
    end else if (tick) begin
      if (!updown) begin
        count_next = at_period ? `PTB_COUNT_RST : count_reg + 15'h0001;
        dir_next = 1'b0;
      end else if (!dir_reg) begin
        if (at_period) begin
          count_next = count_reg - 15'h0001;
          dir_next = 1'b1;
        end else begin
          count_next = count_reg + 15'h0001;
        end
      end else begin
        if (at_zero) begin
          count_next = count_reg + 15'h0001;
          dir_next = 1'b0;
        end else begin
          count_next = count_reg - 15'h0001;
        end
      end
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = ctrl_wr_val;
      ctrl_next.spare = 7'h00;
    end else if (shot_end) begin
      ctrl_next.run = 1'b0;
    end
  end

  always_comb begin
    pre_cnt_next = pre_cnt_reg;
    if (!ctrl_reg.run || wr_count || tick) begin
      pre_cnt_next = 6'h00;
    end else if (active) begin
      pre_cnt_next = pre_cnt_reg + 6'h01;
    end
  end

  always_comb begin
    post_cnt_next = post_cnt_reg;
    if (!ctrl_reg.run) begin
      post_cnt_next = 4'h0;
    end else if (ev_raw && !is_shot) begin
      post_cnt_next = post_hit ? 4'h0 : post_cnt_reg + 4'h1;
    end
  end

  assign period_next = (wr_period && !period_locked) ?
                       period_wr_val[`PTB_CNT_W-1:0] : period_reg;
  assign sevcmp_next = wr_sevcmp ? sevcmp_wr_val[`PTB_CNT_W-1:0] : sevcmp_reg;

  // ***************************************************************
  // interrupt status: a new event wins over a clear
  // ***************************************************************
  wire ptb_evt_t evt_now = '{special: sev_hit, period: tb_event};
  wire [1:0] clr_mask = wr_clear ? dat_i[1:0] : 2'h0;
  assign status_next = (status_reg & ~clr_mask) | evt_now;
  assign enable_next = wr_enable ? dat_i[1:0] : enable_reg;
  assign dat_next = rd_take ? {16'h0000, rd_mux} : dat_reg;

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `PTB_CTRL_RST;
      count_reg <= `PTB_COUNT_RST;
      dir_reg <= 1'b0;
      period_reg <= `PTB_PERIOD_RST;
      sevcmp_reg <= `PTB_SEVCMP_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      dir_reg <= dir_next;
      period_reg <= period_next;
      sevcmp_reg <= sevcmp_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_reg <= 6'h00;
      post_cnt_reg <= 4'h0;
      status_reg <= `PTB_EVT_RST;
      enable_reg <= `PTB_EVT_RST;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
      post_cnt_reg <= post_cnt_next;
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      evt_reg <= 1'b0;
      sev_reg <= 1'b0;
    end else begin
      ack_reg <= rd_take;
      dat_reg <= dat_next;
      evt_reg <= tb_event;
      sev_reg <= sev_hit;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign tb_event_o = evt_reg;
  assign special_event_o = sev_reg;
  assign irq_o = |(status_reg & enable_reg);

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_dir_readback: assert property (
    rd_take && !we_i && hit_count |=> dat_o[`PTB_DIR_BIT] == $past(dir_reg))
    else $error("direction bit not returned in count read");

  chk_stop_holds: assert property (
    !ctrl_reg.run && !wr_count |=> count_reg == $past(count_reg))
    else $error("count moved while stopped");

  chk_free_wrap: assert property (
    is_free && up_match && !wr_count |=> count_reg == `PTB_COUNT_RST)
    else $error("free mode did not wrap to zero");

  chk_zero_period: assert property (
    zero_period |=> !tb_event_o && !special_event_o)
    else $error("event raised with zero period");

  chk_period_lock: assert property (
    wr_period && period_locked |=> period_reg == `PTB_PERIOD_RST)
    else $error("period updated while locked at zero");

  chk_shot_end: assert property (
    shot_end && !wr_ctrl |=> !ctrl_reg.run ##1 !tb_event_o || ctrl_reg.run)
    else $error("single shot did not stop");

  chk_updown_turn: assert property (
    updown && up_match && !wr_count
    |=> dir_reg && count_reg == $past(count_reg) - 15'h0001)
    else $error("up/down did not reverse at period");

  chk_post_clear: assert property (
    !ctrl_reg.run |=> post_cnt_reg == 4'h0)
    else $error("postscaler not cleared while stopped");

  chk_zero_event: assert property (
    ctrl_reg.mode == ptb_updn && tb_event |-> down_turn)
    else $error("up/down event away from zero turnaround");

  chk_double_event: assert property (
    is_dbl && up_match && post_hit |=> tb_event_o)
    else $error("double update mode missed period event");

  chk_shot_nopost: assert property (
    shot_end |=> tb_event_o)
    else $error("single shot event suppressed");

  chk_sticky_set: assert property (
    tb_event |=> status_reg.period)
    else $error("period event not latched in status");

  chk_status_hold: assert property (
    status_reg.period && !(wr_clear && dat_i[0]) |=> status_reg.period)
    else $error("period status dropped without a clear");

  chk_free_count: assert property (
    is_free && tick && !at_period && !wr_count |=> count_reg == $past(count_reg) + 15'h0001)
    else $error("free mode did not count up");

  chk_free_event: assert property (
    is_free && up_match && post_hit |=> tb_event_o)
    else $error("free mode missed period event");

  chk_zero_turn: assert property (
    ctrl_reg.mode == ptb_updn && down_turn && post_hit |=> tb_event_o)
    else $error("up/down missed zero turnaround event");

  chk_down_count: assert property (
    updown && tick && dir_reg && !at_zero && !wr_count
    |=> dir_reg && count_reg == $past(count_reg) - 15'h0001)
    else $error("up/down did not count down");

  chk_mode_dir: assert property (
    !updown && tick && !wr_count |=> !dir_reg)
    else $error("direction flag set outside up/down modes");

  chk_zero_stall: assert property (
    zero_period && !wr_count |=> count_reg == $past(count_reg))
    else $error("count moved with zero period");

  chk_post_step: assert property (
    !is_shot && ev_raw && !post_hit |=> post_cnt_reg == $past(post_cnt_reg) + 4'h1)
    else $error("postscaler did not advance on event");

  chk_pre_clear: assert property (
    !ctrl_reg.run |=> pre_cnt_reg == 6'h00)
    else $error("prescaler not cleared while stopped");

endmodule
`default_nettype wire
